/* logic/fsl_pkg.sv */
// constants and types shared by the flash status and block lock design
// assumes a single 125 MHz clock domain
package fsl_pkg;
  localparam int NUM_BLOCKS = 50;
  localparam int NUM_LOCKS = 35;
  localparam int SHARED_TOP_BLOCK = 15;
  localparam int TOP_BLOCK = 49;
  localparam int LOCK_IDX_W = 6;
  localparam int BLOCK_IDX_W = 6;
  localparam int SYNC_STAGES = 2;

  // status register bit positions
  localparam int ST_READY = 7;
  localparam int ST_ERASE_SUSP = 6;
  localparam int ST_ERASE_FAIL = 5;
  localparam int ST_PROG_FAIL = 4;
  localparam int ST_SUPPLY_ERR = 3;
  localparam int ST_PROG_SUSP = 2;
  localparam int ST_PROTECT = 1;

  // lock register bit positions
  localparam int LK_WRITE = 0;
  localparam int LK_DOWN = 1;
  localparam int LK_READ = 2;
  localparam logic [7:0] LK_RESET = 8'h01;
  localparam logic [7:0] LK_USED_MASK = 8'h07;
  localparam logic [7:0] READ_LOCKED_DATA = 8'h00;

  // fixed operation length, in cycles
  localparam int OP_CYCLES = 16;
  localparam int OP_CNT_W = 5;

  typedef enum logic [2:0] {
    FSL_OP_NONE,
    FSL_OP_PROGRAM,
    FSL_OP_QUAD_PROGRAM,
    FSL_OP_BLOCK_ERASE,
    FSL_OP_CHIP_ERASE
  } fsl_op_t;
endpackage

/* logic/fsl_lock_bank.sv */
// bank of per-block lock registers; blocks 0..15 share entry 0
// assumes a synchronous active-low reset copy from the top module
`timescale 1ns/1ps
module fsl_lock_bank
  import fsl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [LOCK_IDX_W-1:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [LOCK_IDX_W-1:0] rd_idx_i,
  output logic [7:0] rd_data_o,
  output logic [NUM_LOCKS-1:0] wlock_o,
  output logic [NUM_LOCKS-1:0] rlock_o
);
  logic [7:0] lock_r [NUM_LOCKS];

  genvar g;
  generate
    for (g = 0; g < NUM_LOCKS; g++) begin : g_lock
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          lock_r[g] <= LK_RESET;
        end else if (wr_i && wr_idx_i == LOCK_IDX_W'(g)
                     && !lock_r[g][LK_DOWN]) begin
          lock_r[g] <= wr_data_i & LK_USED_MASK;
        end
      end
      assign wlock_o[g] = lock_r[g][LK_WRITE];
      assign rlock_o[g] = lock_r[g][LK_READ];
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= LK_RESET;
    end else if (rd_idx_i < LOCK_IDX_W'(NUM_LOCKS)) begin
      rd_data_o <= lock_r[rd_idx_i];
    end else begin
      rd_data_o <= 8'h00;
    end
  end
endmodule

/* logic/fsl_protect.sv */
// combinational write protection decision for one target block
// assumes lock vectors are indexed by lock register, not block
`timescale 1ns/1ps
module fsl_protect
  import fsl_pkg::*;
(
  input wire logic [BLOCK_IDX_W-1:0] block_i,
  input wire logic [NUM_LOCKS-1:0] wlock_i,
  input wire logic supply_low_i,
  input wire logic top_block_protect_pin_n_i,
  input wire logic array_protect_n_i,
  output logic protected_o
);
  logic [LOCK_IDX_W-1:0] idx;

  always_comb begin
    if (block_i <= BLOCK_IDX_W'(SHARED_TOP_BLOCK)) begin
      idx = '0;
    end else begin
      idx = LOCK_IDX_W'(block_i - BLOCK_IDX_W'(SHARED_TOP_BLOCK));
    end
    protected_o = 1'b0;
    if (idx < LOCK_IDX_W'(NUM_LOCKS) && wlock_i[idx]) begin
      protected_o = 1'b1;
    end
    if (supply_low_i) begin
      protected_o = 1'b1;
    end
    if (block_i == BLOCK_IDX_W'(TOP_BLOCK) && !top_block_protect_pin_n_i) begin
      protected_o = 1'b1;
    end
    if (block_i < BLOCK_IDX_W'(TOP_BLOCK) && !array_protect_n_i) begin
      protected_o = 1'b1;
    end
  end
endmodule

/* logic/fsl_top.sv */
// status reporting and block lock for a flash program/erase controller
// assumes command decoding and the bus cycle protocol sit outside;
// commands arrive as one-cycle strobes synchronous to clk_i
`timescale 1ns/1ps
module fsl_top
  import fsl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // command strobes from the decoder
  input wire logic cmd_program_i,
  input wire logic cmd_quad_program_i,
  input wire logic cmd_block_erase_i,
  input wire logic cmd_chip_erase_i,
  input wire logic [BLOCK_IDX_W-1:0] cmd_block_i,
  input wire logic cmd_suspend_i,
  input wire logic cmd_resume_i,
  input wire logic cmd_clear_status_i,
  input wire logic cmd_invalid_i,
  // verify result from the array engine at end of an operation
  input wire logic verify_fail_i,
  // supply comparators and protect pins
  input wire logic supply_lockout_level_i,
  input wire logic fast_program_supply_level_i,
  input wire logic top_block_protect_pin_n_i,
  input wire logic array_protect_n_i,
  input wire logic mux_mode_i,
  // lock register access
  input wire logic lock_wr_i,
  input wire logic [LOCK_IDX_W-1:0] lock_idx_i,
  input wire logic [7:0] lock_wdata_i,
  output logic [7:0] lock_rdata_o,
  // array read gating
  input wire logic [BLOCK_IDX_W-1:0] rd_block_i,
  input wire logic [7:0] array_data_i,
  output logic [7:0] array_rdata_o,
  // status and array strobe
  output logic [7:0] status_o,
  output logic array_write_o
);
  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic [SYNC_STAGES-1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= '0;
    end else begin
      rst_sync_r <= {rst_sync_r[SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////
  // locks and protection
  logic [NUM_LOCKS-1:0] wlock;
  logic [NUM_LOCKS-1:0] rlock;
  logic cmd_protected;

  fsl_lock_bank u_locks (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .wr_i(lock_wr_i),
    .wr_idx_i(lock_idx_i),
    .wr_data_i(lock_wdata_i),
    .rd_idx_i(lock_idx_i),
    .rd_data_o(lock_rdata_o),
    .wlock_o(wlock),
    .rlock_o(rlock)
  );

  fsl_protect u_protect (
    .block_i(cmd_block_i),
    .wlock_i(wlock),
    .supply_low_i(supply_lockout_level_i),
    .top_block_protect_pin_n_i(top_block_protect_pin_n_i),
    .array_protect_n_i(array_protect_n_i),
    .protected_o(cmd_protected)
  );

  ////////////////////////////////////////////////////////////////////////
  // read gating
  logic [LOCK_IDX_W-1:0] rd_lock_idx;

  always_comb begin
    if (rd_block_i <= BLOCK_IDX_W'(SHARED_TOP_BLOCK)) begin
      rd_lock_idx = '0;
    end else begin
      rd_lock_idx = LOCK_IDX_W'(rd_block_i - BLOCK_IDX_W'(SHARED_TOP_BLOCK));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      array_rdata_o <= 8'h00;
    end else if (rd_lock_idx < LOCK_IDX_W'(NUM_LOCKS)
                 && rlock[rd_lock_idx]) begin
      array_rdata_o <= READ_LOCKED_DATA;
    end else begin
      array_rdata_o <= array_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // controller state
  typedef enum logic [2:0] {
    FSL_IDLE,
    FSL_ERASE,
    FSL_PROGRAM,
    FSL_ERASE_SUSP,
    FSL_PROG_SUSP,
    FSL_PROG_IN_ESUSP
  } fsl_state_t;

  fsl_state_t state_r;
  fsl_state_t state_nxt;
  logic [OP_CNT_W-1:0] cnt_r;
  logic prog_cmd;
  logic erase_cmd;
  logic start_ok;
  logic sticky_err;
  logic done;

  assign prog_cmd = cmd_program_i | cmd_quad_program_i;
  assign erase_cmd = cmd_block_erase_i | cmd_chip_erase_i;
  assign sticky_err = status_o[ST_PROG_FAIL] | status_o[ST_ERASE_FAIL]
                      | status_o[ST_SUPPLY_ERR] | status_o[ST_PROTECT];
  // a leftover error makes the next command fail without touching the array
  // supply sampled here, at the start only; no tracking afterwards
  assign start_ok = !sticky_err && !cmd_protected
                    && !(cmd_quad_program_i && !fast_program_supply_level_i);
  assign done = (cnt_r == OP_CNT_W'(OP_CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FSL_IDLE: begin
        if (prog_cmd && start_ok) begin
          state_nxt = FSL_PROGRAM;
        end else if (erase_cmd && start_ok) begin
          state_nxt = FSL_ERASE;
        end
      end
      FSL_ERASE: begin
        if (done) begin
          state_nxt = FSL_IDLE;
        end else if (cmd_suspend_i) begin
          state_nxt = FSL_ERASE_SUSP;
        end
      end
      FSL_PROGRAM: begin
        if (done) begin
          state_nxt = FSL_IDLE;
        end else if (cmd_suspend_i) begin
          state_nxt = FSL_PROG_SUSP;
        end
      end
      FSL_ERASE_SUSP: begin
        if (cmd_resume_i) begin
          state_nxt = FSL_ERASE;
        end else if (cmd_program_i && start_ok) begin
          state_nxt = FSL_PROG_IN_ESUSP;
        end
      end
      FSL_PROG_SUSP: begin
        if (cmd_resume_i) begin
          state_nxt = FSL_PROGRAM;
        end
      end
      FSL_PROG_IN_ESUSP: begin
        if (done) begin
          state_nxt = FSL_ERASE_SUSP;
        end
      end
      default: begin
        state_nxt = FSL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= FSL_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // counter restarts on a start from idle or erase suspend and holds while paused; a program in erase suspend clears the erase count
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (state_nxt == FSL_IDLE || state_nxt != state_r
                 && state_r == FSL_ERASE_SUSP && !cmd_resume_i
                 || state_r == FSL_IDLE
                 || done && state_r == FSL_PROG_IN_ESUSP) begin
      cnt_r <= '0;
    end else if (state_r == FSL_ERASE || state_r == FSL_PROGRAM
                 || state_r == FSL_PROG_IN_ESUSP) begin
      cnt_r <= cnt_r + OP_CNT_W'(1);
    end
  end

  // one array write strobe when an operation completes cleanly
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      array_write_o <= 1'b0;
    end else begin
      array_write_o <= done && !verify_fail_i
                       && (state_r == FSL_PROGRAM || state_r == FSL_ERASE
                           || state_r == FSL_PROG_IN_ESUSP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags; a set in the same cycle as clear-status wins
  logic start_cmd;
  logic prog_end;
  logic erase_end;
  logic [7:0] st_r;

  assign start_cmd = (state_r == FSL_IDLE && (prog_cmd || erase_cmd))
                     || (state_r == FSL_ERASE_SUSP && cmd_program_i);
  assign prog_end = done && (state_r == FSL_PROGRAM
                             || state_r == FSL_PROG_IN_ESUSP);
  assign erase_end = done && state_r == FSL_ERASE;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r[ST_PROG_FAIL] <= 1'b0;
    end else if (prog_end && verify_fail_i || cmd_invalid_i) begin
      st_r[ST_PROG_FAIL] <= 1'b1;
    end else if (cmd_clear_status_i) begin
      st_r[ST_PROG_FAIL] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r[ST_ERASE_FAIL] <= 1'b0;
    end else if (erase_end && verify_fail_i || cmd_invalid_i) begin
      st_r[ST_ERASE_FAIL] <= 1'b1;
    end else if (cmd_clear_status_i) begin
      st_r[ST_ERASE_FAIL] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r[ST_SUPPLY_ERR] <= 1'b0;
    end else if (start_cmd && (supply_lockout_level_i
                 || cmd_quad_program_i && !fast_program_supply_level_i)) begin
      st_r[ST_SUPPLY_ERR] <= 1'b1;
    end else if (cmd_clear_status_i) begin
      st_r[ST_SUPPLY_ERR] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r[ST_PROTECT] <= 1'b0;
    end else if (start_cmd && cmd_protected && !cmd_chip_erase_i
                 && !mux_mode_i && !supply_lockout_level_i) begin
      st_r[ST_PROTECT] <= 1'b1;
    end else if (cmd_clear_status_i) begin
      st_r[ST_PROTECT] <= 1'b0;
    end
  end

  // unused bits of the flag vector, kept zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      {st_r[7:6], st_r[2], st_r[0]} <= 4'h0;
    end else begin
      {st_r[7:6], st_r[2], st_r[0]} <= 4'h0;
    end
  end

  // assembled status; bit 0 reserved and zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_o <= 8'h80;
    end else begin
      status_o[ST_READY] <= !(state_nxt == FSL_ERASE
                              || state_nxt == FSL_PROGRAM
                              || state_nxt == FSL_PROG_IN_ESUSP);
      status_o[ST_ERASE_SUSP] <= state_nxt == FSL_ERASE_SUSP
                                 || state_nxt == FSL_PROG_IN_ESUSP;
      status_o[ST_PROG_SUSP] <= state_nxt == FSL_PROG_SUSP;
      status_o[ST_ERASE_FAIL] <= st_r[ST_ERASE_FAIL];
      status_o[ST_PROG_FAIL] <= st_r[ST_PROG_FAIL];
      status_o[ST_SUPPLY_ERR] <= st_r[ST_SUPPLY_ERR];
      status_o[ST_PROTECT] <= st_r[ST_PROTECT] && !mux_mode_i;
      status_o[0] <= 1'b0;
    end
  end
endmodule

/* dv/fsl_props.sv */
// checker for the flash status and block lock top, port level only
// assumes it is bound to fsl_top and sees a single clock domain
`timescale 1ns/1ps
module fsl_props
  import fsl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_program_i,
  input wire logic cmd_quad_program_i,
  input wire logic cmd_block_erase_i,
  input wire logic cmd_chip_erase_i,
  input wire logic cmd_clear_status_i,
  input wire logic cmd_invalid_i,
  input wire logic verify_fail_i,
  input wire logic mux_mode_i,
  input wire logic [7:0] status_o,
  input wire logic array_write_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////
  a_reserved_zero: assert property (status_o[0] == 1'h0)
    else $error("reserved status bit not zero");
  // a start in the same cycle could set a flag, and set wins
  a_clear_flags: assert property (cmd_clear_status_i && status_o[ST_READY]
    && !cmd_invalid_i && !cmd_program_i && !cmd_quad_program_i
    && !cmd_block_erase_i && !cmd_chip_erase_i
    |-> ##2 (status_o & 8'h3A) == 8'h00)
    else $error("clear status left a flag set");
  a_mux_protect: assert property (mux_mode_i [*3]
    |-> status_o[ST_PROTECT] == 1'h0)
    else $error("protection flag seen in mux mode");
  a_write_ready: assert property (array_write_o
    |-> status_o[ST_READY] && !$past(status_o[ST_READY]))
    else $error("array write not at end of busy");
  a_pass_writes: assert property ($rose(status_o[ST_READY])
    && !$past(verify_fail_i) && !status_o[ST_PROG_SUSP]
    && !status_o[ST_ERASE_SUSP] |-> array_write_o)
    else $error("passing operation gave no write");
  a_fail_flag: assert property ($rose(status_o[ST_READY])
    && $past(verify_fail_i) && !status_o[ST_PROG_SUSP]
    && !status_o[ST_ERASE_SUSP]
    |=> status_o[ST_PROG_FAIL] || status_o[ST_ERASE_FAIL])
    else $error("failed verify not flagged");
  a_prog_hold: assert property (status_o[ST_PROG_FAIL]
    && !cmd_clear_status_i && !$past(cmd_clear_status_i)
    |=> status_o[ST_PROG_FAIL])
    else $error("program failure flag dropped");
  a_supply_hold: assert property (status_o[ST_SUPPLY_ERR]
    && !cmd_clear_status_i && !$past(cmd_clear_status_i)
    |=> status_o[ST_SUPPLY_ERR])
    else $error("supply error flag dropped");
  a_invalid_seq: assert property (cmd_invalid_i && status_o[ST_READY]
    && !status_o[ST_PROG_SUSP] && !status_o[ST_ERASE_SUSP]
    |-> ##2 status_o[ST_ERASE_FAIL] && status_o[ST_PROG_FAIL]
    && status_o[ST_READY])
    else $error("invalid sequence not flagged");
  a_refuse_start: assert property (cmd_program_i && status_o[ST_PROG_FAIL]
    && status_o[ST_READY] |=> status_o[ST_READY])
    else $error("start taken with failure flag set");
endmodule

bind fsl_top fsl_props u_props (.clk_i, .rst_n_i, .cmd_program_i,
  .cmd_quad_program_i, .cmd_block_erase_i, .cmd_chip_erase_i,
  .cmd_clear_status_i, .cmd_invalid_i, .verify_fail_i, .mux_mode_i,
  .status_o, .array_write_o);

/* dv/fsl_host.sv */
// host side model: array contents and how the host reads status
// assumes the array pattern only needs to differ per block and be nonzero
`timescale 1ns/1ps
module fsl_host
  import fsl_pkg::*;
(
  input wire logic [BLOCK_IDX_W-1:0] rd_block_i,
  input wire logic [7:0] status_i,
  output logic [7:0] array_data_o,
  output logic [7:0] status_seen_o,
  output logic susp_valid_o
);
  // nonzero so a read-locked 00 can never pass by chance
  assign array_data_o = {2'h2, rd_block_i};
  assign status_seen_o = status_i & 8'hFE;
  assign susp_valid_o = status_i[ST_READY];
endmodule

/* dv/testbench.sv */
// self-checking bench for the flash status and block lock top
// assumes inputs change on the falling edge of a 125 MHz clock
`timescale 1ns/1ps
module testbench;
  import fsl_pkg::*;
  localparam int PRG = 0, QPR = 1, BER = 2, SUS = 4, RES = 5;
  localparam int CLR = 6, INV = 7;
  logic clk, rst_n, vfail, slow, sfast, tbp_n, ap_n, mux, lwr, aw, sv;
  logic [7:0] cmd, lwd, lrd, adata, ard, sraw, st;
  logic [5:0] blk, lidx, rblk;
  int n_mismatch = 0;
  int n_checks = 0;

  fsl_top dut (.clk_i(clk), .rst_n_i(rst_n), .cmd_program_i(cmd[0]),
    .cmd_quad_program_i(cmd[1]), .cmd_block_erase_i(cmd[2]),
    .cmd_chip_erase_i(cmd[3]), .cmd_block_i(blk),
    .cmd_suspend_i(cmd[4]), .cmd_resume_i(cmd[5]),
    .cmd_clear_status_i(cmd[6]), .cmd_invalid_i(cmd[7]),
    .verify_fail_i(vfail), .supply_lockout_level_i(slow),
    .fast_program_supply_level_i(sfast),
    .top_block_protect_pin_n_i(tbp_n), .array_protect_n_i(ap_n),
    .mux_mode_i(mux), .lock_wr_i(lwr), .lock_idx_i(lidx),
    .lock_wdata_i(lwd), .lock_rdata_o(lrd), .rd_block_i(rblk),
    .array_data_i(adata), .array_rdata_o(ard), .status_o(sraw),
    .array_write_o(aw));
  fsl_host host (.rd_block_i(rblk), .status_i(sraw),
    .array_data_o(adata), .status_seen_o(st), .susp_valid_o(sv));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(input int k, input logic [5:0] b);
    @(negedge clk);
    cmd[k] = 1'h1;
    blk = b;
    @(negedge clk);
    cmd = 8'h00;
  endtask

  // counts write strobes over the whole op so a refusal shows as zero
  task automatic op_chk(input int k, input logic [5:0] b,
      input logic [7:0] es, ew, input logic [7:0] m = 8'hFF);
    logic [7:0] w;
    w = 8'h00;
    pulse(k, b);
    repeat (20) begin
      @(negedge clk);
      w = w + {7'h00, aw};
    end
    chk("status", st & m, es);
    chk("writes", w, ew);
  endtask

  task automatic clear(input logic [7:0] es);
    pulse(CLR, 6'h00);
    idle(3);
    chk("status", st, es);
  endtask

  task automatic lock_wr(input logic [5:0] i, input logic [7:0] d);
    @(negedge clk);
    lwr = 1'h1;
    lidx = i;
    lwd = d;
    @(negedge clk);
    lwr = 1'h0;
  endtask

  task automatic lock_chk(input logic [5:0] i, input logic [7:0] e);
    @(negedge clk);
    lidx = i;
    @(negedge clk);
    chk("lock", lrd, e);
  endtask

  task automatic do_reset;
    rst_n = 1'h0;
    idle(4);
    rst_n = 1'h1;
    idle(3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("status", st, 8'h80);
    lock_chk(6'h00, 8'h01);
    lock_chk(6'h22, 8'h01);
    chk("array", ard, 8'h85);
  endtask

  task automatic t_lock;
    lock_wr(6'h00, 8'h00);
    op_chk(PRG, 6'h0F, 8'h80, 8'h01);
    op_chk(PRG, 6'h10, 8'h82, 8'h00);
    clear(8'h80);
    lock_wr(6'h03, 8'h07);
    lock_chk(6'h03, 8'h07);
    rblk = 6'h12;
    idle(2);
    chk("array", ard, 8'h00);
    lock_wr(6'h03, 8'h00);
    lock_chk(6'h03, 8'h07);
    chk("status", st, 8'h80);
  endtask

  task automatic t_prot;
    lock_wr(6'h05, 8'h00);
    op_chk(PRG, 6'h14, 8'h80, 8'h01);
    ap_n = 1'h0;
    op_chk(PRG, 6'h14, 8'h82, 8'h00);
    ap_n = 1'h1;
    op_chk(PRG, 6'h14, 8'h82, 8'h00);
    clear(8'h80);
    lock_wr(6'h22, 8'h00);
    tbp_n = 1'h0;
    op_chk(BER, 6'h31, 8'h82, 8'h00);
    clear(8'h80);
    tbp_n = 1'h1;
    op_chk(BER, 6'h31, 8'h80, 8'h01);
    slow = 1'h1;
    op_chk(PRG, 6'h14, 8'h88, 8'h00);
    slow = 1'h0;
    op_chk(PRG, 6'h14, 8'h88, 8'h00);
    clear(8'h80);
    sfast = 1'h0;
    op_chk(QPR, 6'h14, 8'h88, 8'h00);
    sfast = 1'h1;
    clear(8'h80);
    vfail = 1'h1;
    op_chk(PRG, 6'h14, 8'h90, 8'h00);
    vfail = 1'h0;
    op_chk(PRG, 6'h14, 8'h90, 8'h00);
    clear(8'h80);
    pulse(PRG, 6'h14);
    idle(3);
    slow = 1'h1;
    idle(17);
    slow = 1'h0;
    chk("status", st, 8'h80);
    mux = 1'h1;
    pulse(PRG, 6'h1E);
    idle(20);
    chk("protect", st & 8'h02, 8'h00);
    mux = 1'h0;
    clear(8'h80);
  endtask

  task automatic t_cmds;
    pulse(INV, 6'h00);
    idle(3);
    chk("status", st, 8'hB0);
    clear(8'h80);
    pulse(PRG, 6'h14);
    idle(4);
    pulse(SUS, 6'h00);
    idle(3);
    chk("valid", {7'h00, sv}, 8'h01);
    chk("status", st, 8'h84);
    pulse(RES, 6'h00);
    idle(2);
    chk("status", st, 8'h00);
    idle(20);
    chk("status", st, 8'h80);
    pulse(BER, 6'h14);
    idle(4);
    pulse(SUS, 6'h00);
    idle(3);
    chk("status", st, 8'hC0);
    pulse(PRG, 6'h07);
    idle(2);
    chk("status", st, 8'h40);
    idle(20);
    chk("status", st, 8'hC0);
    pulse(RES, 6'h00);
    idle(20);
    chk("status", st, 8'h80);
  endtask

  task automatic t_relock;
    do_reset;
    lock_chk(6'h03, 8'h01);
    lock_chk(6'h00, 8'h01);
  endtask

  // the tests need well under 2000 cycles, so this only trips on a hang
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    cmd = 8'h00;
    blk = 6'h00;
    vfail = 1'h0;
    slow = 1'h0;
    sfast = 1'h1;
    tbp_n = 1'h1;
    ap_n = 1'h1;
    mux = 1'h0;
    lwr = 1'h0;
    lwd = 8'h00;
    lidx = 6'h00;
    rblk = 6'h05;
    do_reset;
    t_reset;
    t_lock;
    t_prot;
    t_cmds;
    t_relock;
    wrap_up;
  end
endmodule
